//--- rsd_defines.svh
// Register offsets, field positions, reset values and fixed levels of the strap and drive block.
`ifndef RSD_DEFINES_SVH
`define RSD_DEFINES_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define RSD_STRAP_OFS      12'h000
`define RSD_DRIVE_OFS      12'h004
`define RSD_CTRL_OFS       12'h008

// ****************************************************************
// Strap status fields
// ****************************************************************
`define RSD_ST_BOOT_BIT    0
`define RSD_ST_IRQ_BIT     1
`define RSD_ST_TSTA_BIT    2
`define RSD_ST_TSTB_BIT    3
`define RSD_ST_TERR_BIT    4
`define RSD_ST_SAMP_BIT    5

// ****************************************************************
// Drive status fields
// ****************************************************************
`define RSD_DR_ADC_LSB     0
`define RSD_DR_LINK_LSB    4
`define RSD_DR_DS_LSB      8
`define RSD_DR_IMP_LSB     12
`define RSD_DR_ADCEN_BIT   16
`define RSD_DR_LINKEN_BIT  17

// ****************************************************************
// Control fields and reset values
// ****************************************************************
`define RSD_CT_USESW_BIT   0
`define RSD_CT_CODE_LSB    1
`define RSD_CTRL_USESW_RST 1'b0
`define RSD_CTRL_CODE_RST  3'h7
`define RSD_STRENGTH_MAX   3'h7

// ****************************************************************
// Impedance control codes
// ****************************************************************
`define RSD_IMP_NONE_A     3'h0
`define RSD_IMP_NONE_B     3'h1
`define RSD_IMP_LINK       3'h2
`define RSD_IMP_ADC        3'h4
`define RSD_IMP_BOTH       3'h6

`endif

//--- rsd_pkg.sv
// Types shared by the strap and drive block.
package rsd_pkg;
    typedef logic [2:0] rsd_strength_t;
    typedef enum logic [1:0] {
        RSD_SEL_NONE = 2'b00,
        RSD_SEL_LINK = 2'b01,
        RSD_SEL_ADC  = 2'b10,
        RSD_SEL_BOTH = 2'b11
    } rsd_dig_sel_t;
endpackage

//--- rsd_sync3.sv
// Three-stage pin synchroniser with an agreement filter.
module rsd_sync3 #(
    parameter int W = 1
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_clk_en,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_level
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] lvl_q;
    logic [W-1:0] lvl_d;

    // A bit moves only when the second and third stages agree.
    always_comb begin
        lvl_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
    end

    // No reset here: the straps are sampled while reset is held, so these must keep running.
    always_ff @(posedge i_sys_clk) begin
        if (i_clk_en) begin
            s1_q  <= i_async;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign o_level = lvl_q;
endmodule

//--- rsd_strap_drive.sv
// Reset strap capture, drive strength selection and its APB register file.
//
// The address map and the APB slave port are this design's own decisions.
`include "rsd_defines.svh"
module rsd_strap_drive import rsd_pkg::*; #(
    parameter int AW = 12
) (
    input  wire logic          i_sys_clk,
    input  wire logic          i_rst_n,
    input  wire logic          i_clk_en,
    input  wire logic          i_boot_memory_select_pin,
    input  wire logic          i_bus_master_pin,
    input  wire logic          i_link_two_direction_pin,
    input  wire logic          i_timer_expired_pin,
    input  wire logic [2:0]    i_drive_select_code,
    input  wire logic [2:0]    i_impedance_control_code,
    input  wire logic          i_psel,
    input  wire logic          i_penable,
    input  wire logic          i_pwrite,
    input  wire logic [AW-1:0] i_paddr,
    input  wire logic [31:0]   i_pwdata,
    output logic [31:0]        o_prdata,
    output logic               o_pready,
    output logic               o_pslverr,
    output logic               o_strap_sampling,
    output logic               o_boot_from_eprom,
    output logic               o_wait_external_boot,
    output logic               o_irq_enable,
    output logic               o_irq_edge_sense,
    output logic               o_test_mode_error,
    output rsd_strength_t      o_adc_strength,
    output rsd_strength_t      o_link_strength,
    output rsd_strength_t      o_fixed_strength
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [9:0]    pins_f;
    logic [3:0]    strap_f;
    rsd_strength_t ds_f;
    logic [2:0]    imp_f;

    rsd_sync3 #(.W(10)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_clk_en  (i_clk_en),
        .i_async   ({i_impedance_control_code, i_drive_select_code,
                     i_timer_expired_pin, i_link_two_direction_pin,
                     i_bus_master_pin, i_boot_memory_select_pin}),
        .o_level   (pins_f)
    );

    assign strap_f = pins_f[3:0];
    assign ds_f    = pins_f[6:4];
    assign imp_f   = pins_f[9:7];

    // ****************************************************************
    // Strap capture
    // ****************************************************************
    logic [3:0] strap_q;
    logic [3:0] strap_d;
    logic       samp_q;
    logic       samp_d;

    always_comb begin
        strap_d = strap_q;
        samp_d  = 1'b0;
        if (!i_rst_n) begin
            strap_d = strap_f;
            samp_d  = 1'b1;
        end
    end

    // Held values change only under reset, so the pins may go back to normal duty after it.
    always_ff @(posedge i_sys_clk) begin
        if (i_clk_en) begin
            strap_q <= strap_d;
            samp_q  <= samp_d;
        end
    end

    // ****************************************************************
    // Drive strength selection and mode outputs
    // ****************************************************************
    logic          use_sw_q;
    logic          use_sw_d;
    rsd_strength_t sw_code_q;
    rsd_strength_t sw_code_d;
    rsd_dig_sel_t  dig_sel;
    rsd_strength_t code_eff;
    rsd_strength_t adc_d;
    rsd_strength_t link_d;
    rsd_strength_t adc_q;
    rsd_strength_t link_q;
    rsd_strength_t fixed_q;
    logic          boot_q;
    logic          wait_q;
    logic          irq_q;
    logic          edge_q;
    logic          terr_q;

    // Reserved impedance codes fall back to full drive rather than guess a level.
    always_comb begin
        if (imp_f == `RSD_IMP_LINK) begin
            dig_sel = RSD_SEL_LINK;
        end else if (imp_f == `RSD_IMP_ADC) begin
            dig_sel = RSD_SEL_ADC;
        end else if (imp_f == `RSD_IMP_BOTH) begin
            dig_sel = RSD_SEL_BOTH;
        end else begin
            dig_sel = RSD_SEL_NONE;
        end
        code_eff = use_sw_q ? sw_code_q : ds_f;
        adc_d    = dig_sel[1] ? code_eff : `RSD_STRENGTH_MAX;
        link_d   = dig_sel[0] ? code_eff : `RSD_STRENGTH_MAX;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_clk_en && !i_rst_n) begin
            adc_q   <= `RSD_STRENGTH_MAX;
            link_q  <= `RSD_STRENGTH_MAX;
            fixed_q <= `RSD_STRENGTH_MAX;
            boot_q  <= 1'b0;
            wait_q  <= 1'b0;
            irq_q   <= 1'b0;
            edge_q  <= 1'b0;
            terr_q  <= 1'b0;
        end else if (i_clk_en) begin
            adc_q   <= adc_d;
            link_q  <= link_d;
            fixed_q <= `RSD_STRENGTH_MAX;
            boot_q  <= ~strap_q[0];
            wait_q  <= strap_q[0];
            irq_q   <= strap_q[1];
            edge_q  <= strap_q[1];
            terr_q  <= strap_q[2] | strap_q[3];
        end
    end

    // ****************************************************************
    // APB register file
    // ****************************************************************
    logic        rdy_q;
    logic        rdy_d;
    logic        err_q;
    logic        err_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        access;
    logic        commit;

    assign access = i_psel & i_penable & ~rdy_q;
    assign commit = i_psel & i_penable & rdy_q;

    always_comb begin
        rdy_d     = access;
        err_d     = err_q;
        rdata_d   = rdata_q;
        use_sw_d  = use_sw_q;
        sw_code_d = sw_code_q;
        if (access) begin
            err_d   = 1'b0;
            rdata_d = 32'h0000_0000;
            if (i_paddr == `RSD_STRAP_OFS) begin
                rdata_d[`RSD_ST_BOOT_BIT] = strap_q[0];
                rdata_d[`RSD_ST_IRQ_BIT]  = strap_q[1];
                rdata_d[`RSD_ST_TSTA_BIT] = strap_q[2];
                rdata_d[`RSD_ST_TSTB_BIT] = strap_q[3];
                rdata_d[`RSD_ST_TERR_BIT] = terr_q;
                rdata_d[`RSD_ST_SAMP_BIT] = samp_q;
            end else if (i_paddr == `RSD_DRIVE_OFS) begin
                rdata_d[`RSD_DR_ADC_LSB +: 3]  = adc_q;
                rdata_d[`RSD_DR_LINK_LSB +: 3] = link_q;
                rdata_d[`RSD_DR_DS_LSB +: 3]   = ds_f;
                rdata_d[`RSD_DR_IMP_LSB +: 3]  = imp_f;
                rdata_d[`RSD_DR_ADCEN_BIT]     = dig_sel[1];
                rdata_d[`RSD_DR_LINKEN_BIT]    = dig_sel[0];
            end else if (i_paddr == `RSD_CTRL_OFS) begin
                rdata_d[`RSD_CT_USESW_BIT]     = use_sw_q;
                rdata_d[`RSD_CT_CODE_LSB +: 3] = sw_code_q;
            end else begin
                err_d = 1'b1;
            end
        end
        if (commit && i_pwrite && i_paddr == `RSD_CTRL_OFS) begin
            use_sw_d  = i_pwdata[`RSD_CT_USESW_BIT];
            sw_code_d = i_pwdata[`RSD_CT_CODE_LSB +: 3];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_clk_en && !i_rst_n) begin
            rdy_q     <= 1'b0;
            err_q     <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            use_sw_q  <= `RSD_CTRL_USESW_RST;
            sw_code_q <= `RSD_CTRL_CODE_RST;
        end else if (i_clk_en) begin
            rdy_q     <= rdy_d;
            err_q     <= err_d;
            rdata_q   <= rdata_d;
            use_sw_q  <= use_sw_d;
            sw_code_q <= sw_code_d;
        end
    end

    assign o_prdata             = rdata_q;
    assign o_pready             = rdy_q;
    assign o_pslverr            = err_q;
    assign o_strap_sampling     = samp_q;
    assign o_boot_from_eprom    = boot_q;
    assign o_wait_external_boot = wait_q;
    assign o_irq_enable         = irq_q;
    assign o_irq_edge_sense     = edge_q;
    assign o_test_mode_error    = terr_q;
    assign o_adc_strength       = adc_q;
    assign o_link_strength      = link_q;
    assign o_fixed_strength     = fixed_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_capture;
        @(posedge i_sys_clk)
        (!i_rst_n && i_clk_en) |=> (strap_q == $past(strap_f));
    endproperty
    a_capture: assert property (p_capture) else $error("strap not captured in reset");

    property p_default_low;
        @(posedge i_sys_clk)
        (!i_rst_n && i_clk_en && strap_f == 4'h0) |=> (strap_q == 4'h0);
    endproperty
    a_default_low: assert property (p_default_low) else $error("undriven strap not zero");

    property p_hold;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        $past(i_rst_n) |-> $stable(strap_q);
    endproperty
    a_hold: assert property (p_hold) else $error("captured strap changed after reset");

    property p_boot;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && $past(i_rst_n)) |=> (o_boot_from_eprom == ~strap_q[0])
            && (o_wait_external_boot == strap_q[0]);
    endproperty
    a_boot: assert property (p_boot) else $error("boot mode does not follow strap");

    property p_irq;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && $past(i_rst_n)) |=> (o_irq_enable == strap_q[1])
            && (o_irq_edge_sense == o_irq_enable);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt mode does not follow strap");

    property p_code;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && dig_sel[1] && !use_sw_q) |=> (o_adc_strength == $past(ds_f));
    endproperty
    a_code: assert property (p_code) else $error("drive code not applied");

    property p_maxdrive;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && !dig_sel[0]) |=> (o_link_strength == `RSD_STRENGTH_MAX);
    endproperty
    a_maxdrive: assert property (p_maxdrive) else $error("disabled control not full drive");

    property p_fixed;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        $past(i_rst_n) |-> (o_fixed_strength == 3'h7);
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed strength not seven");

    property p_testerr;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_clk_en && $past(i_rst_n)) |=> (o_test_mode_error == |strap_q[3:2]);
    endproperty
    a_testerr: assert property (p_testerr) else $error("test strap flag wrong");
endmodule

//--- rsd_strap_board.sv
// Board model that holds the strap pins through reset and then runs their normal traffic.
module rsd_strap_board (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic [3:0] i_strap,
    input  wire logic       i_float,
    output logic      [3:0] o_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] run_q;
    always_ff @(posedge i_clk) begin
        run_q <= i_rst_n ? ~run_q : 4'h5;
    end
    // An unconnected strap falls to its pull-down, so the device must read a zero.
    // After reset the pins toggle every cycle, which would spoil a capture that kept following them.
    assign o_pins = i_rst_n ? run_q : (i_float ? 4'h0 : i_strap);
endmodule

//--- reset_strap_and_drive_select_test.sv
// Self-checking bench for the strap capture and drive select block.
module reset_strap_and_drive_select_test import rsd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Stimulus, scoreboard and checks
    // ****************************************************************
    logic          i_sys_clk = 1'h0;
    logic          i_rst_n   = 1'h0;
    logic          psel      = 1'h0;
    logic          penable   = 1'h0;
    logic          pwrite    = 1'h0;
    logic [11:0]   paddr     = 12'h0;
    logic [31:0]   pwdata    = 32'h0;
    logic [31:0]   prdata;
    logic          pready, pslverr, sampling, boot_e, wait_e, irq_en, irq_edge, terr;
    rsd_strength_t adc_s, link_s, fix_s;
    logic [2:0]    ds        = 3'h7;
    logic [2:0]    imp       = 3'h6;
    logic [3:0]    strap     = 4'h0;
    logic [3:0]    pins;
    logic          flt       = 1'h0;
    logic          ce        = 1'h1;
    logic [7:0]    lfsr      = 8'h3e;
    logic [32:0]   expq[$];
    int            mismatches = 0;
    int            num_checks = 0;

    rsd_strap_board rsd_strap_board_inst (.i_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_strap(strap), .i_float(flt), .o_pins(pins));
    rsd_strap_drive rsd_strap_drive_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_clk_en(ce), .i_boot_memory_select_pin(pins[0]), .i_bus_master_pin(pins[1]),
        .i_link_two_direction_pin(pins[2]), .i_timer_expired_pin(pins[3]),
        .i_drive_select_code(ds), .i_impedance_control_code(imp), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_strap_sampling(sampling), .o_boot_from_eprom(boot_e),
        .o_wait_external_boot(wait_e), .o_irq_enable(irq_en), .o_irq_edge_sense(irq_edge),
        .o_test_mode_error(terr), .o_adc_strength(adc_s), .o_link_strength(link_s),
        .o_fixed_strength(fix_s));

    always #12.5 i_sys_clk = ~i_sys_clk;

    function automatic logic [7:0] next_rand(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        if (mismatches == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Each transfer notes its expected response; the monitor compares it when pready comes.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        @(posedge i_sys_clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        expq.push_back(e);
        @(posedge i_sys_clk);
        penable <= 1'h1;
        do @(posedge i_sys_clk); while (pready !== 1'h1);
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    always @(posedge i_sys_clk) begin
        if (psel && penable && pready === 1'h1) begin
            if (expq.size() == 0) check("unexpected response", 33'h0, 33'h1);
            else check("response", {pslverr, pwrite ? 32'h0 : prdata},
                       expq.pop_front());
        end
    end

    task automatic reset_with(input logic [3:0] s, input logic f);
        logic [3:0] es;
        es = f ? 4'h0 : s;
        @(posedge i_sys_clk);
        strap <= s;
        flt <= f;
        i_rst_n <= 1'h0;
        repeat (8) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        check("in reset", {sampling, boot_e, wait_e, irq_en, irq_edge, terr, adc_s, link_s,
              fix_s}, {6'h20, 9'h1ff});
        @(posedge i_sys_clk);
        i_rst_n <= 1'h1;
        repeat (12) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        check("modes", {sampling, boot_e, wait_e, irq_en, irq_edge, terr, fix_s},
              {1'h0, ~es[0], es[0], es[1], es[1], es[2] | es[3], 3'h7});
        apb(1'h0, 12'h000, 32'h0, {27'h0, es[2] | es[3], es});
    endtask

    initial begin
        logic [2:0] c, ea, el;
        logic       ae, le;
        // Every strap combination, including the reserved test settings, with one floating run.
        reset_with(4'hf, 1'h1);
        for (int i = 0; i < 16; i++) reset_with(4'(i), 1'h0);
        apb(1'h0, 12'h008, 32'h0, 33'he);
        for (int i = 0; i < 16; i++) begin
            lfsr = next_rand(lfsr);
            c = i[3] ? lfsr[6:4] : lfsr[2:0];
            ae = i[2:0] inside {3'h4, 3'h6};
            le = i[2:0] inside {3'h2, 3'h6};
            ea = ae ? c : 3'h7;
            el = le ? c : 3'h7;
            @(posedge i_sys_clk);
            ds <= lfsr[2:0];
            imp <= i[2:0];
            apb(1'h1, 12'h008, {28'h0, lfsr[6:4], i[3]}, 33'h0);
            apb(1'h0, 12'h008, 32'h0, {28'h0, lfsr[6:4], i[3]});
            repeat (6) @(posedge i_sys_clk);
            @(negedge i_sys_clk);
            check("strength", {adc_s, link_s, fix_s}, {ea, el, 3'h7});
            apb(1'h0, 12'h004, 32'h0, {14'h0, le, ae, 1'h0, i[2:0], 1'h0, lfsr[2:0], 1'h0,
                el, 1'h0, ea});
        end
        // Read-only places must not change state, and unmapped places must not pass silently.
        apb(1'h1, 12'h000, 32'hffffffff, 33'h0);
        apb(1'h1, 12'h010, 32'h0, {1'h1, 32'h0});
        apb(1'h0, 12'h000, 32'h0, {27'h0, 1'h1, 4'hf});
        apb(1'h0, 12'h00c, 32'h0, {1'h1, 32'h0});
        apb(1'h0, 12'h008, 32'h0, {28'h0, lfsr[6:4], 1'h1});
        // A frozen enable must hold the ADC and link strength outputs even while the pins move.
        apb(1'h1, 12'h008, 32'h5, 33'h0);
        @(posedge i_sys_clk);
        ce  <= 1'h0;
        imp <= 3'h6;
        repeat (8) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        check("frozen", {adc_s, link_s}, 6'h3f);
        @(posedge i_sys_clk);
        ce <= 1'h1;
        repeat (8) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        check("resumed", {adc_s, link_s}, 6'h12);
        repeat (3) @(posedge i_sys_clk);
        check("pending reads", 33'(expq.size()), 33'h0);
        conclude();
    end

    initial begin
        #100us;
        mismatches++;
        conclude();
    end
endmodule
